//--- hdl/vpw_pkg.sv
// Constants, types and timing for the VPW bus node controller.
// Assumes a 40 MHz system clock and a 2 MHz internal timing tick.
package vpw_pkg;

	// ****************************************************************
	// Clocking
	// ****************************************************************
	localparam int CLK_HZ        = 40_000_000;
	localparam int TICK_HZ       = 2_000_000;
	localparam int TICK_DIV      = CLK_HZ / TICK_HZ;
	localparam int TICKS_PER_US  = TICK_HZ / 1_000_000;
	localparam logic [4:0] TICK_LAST = 5'(TICK_DIV - 1);

	// Reference clock fed to the device; divisor brings it to 2 MHz
	localparam int REF_MHZ       = 4;
	localparam logic [1:0] OSC_DIV_FIELD = 2'(REF_MHZ / 2 - 1);

	// ****************************************************************
	// Symbol times in microseconds and in ticks
	// ****************************************************************
	localparam int T_SHORT_US    = 64;
	localparam int T_LONG_US     = 128;
	localparam int T_SOF_US      = 200;
	localparam int T_EOD_US      = 200;
	localparam int T_EOF_US      = 280;
	localparam int T_IFS_US      = 300;
	localparam int T_DEV_RST_US  = 10;
	localparam int T_SETTLE_US   = 2;
	localparam int W_INV_US      = 34;
	localparam int W_SHORT_US    = 96;
	localparam int W_LONG_US     = 163;
	localparam int W_SOF_US      = 239;

	localparam logic [9:0] T_SHORT   = 10'(T_SHORT_US * TICKS_PER_US);
	localparam logic [9:0] T_LONG    = 10'(T_LONG_US * TICKS_PER_US);
	localparam logic [9:0] T_SOF     = 10'(T_SOF_US * TICKS_PER_US);
	localparam logic [9:0] T_EOD     = 10'(T_EOD_US * TICKS_PER_US);
	localparam logic [9:0] T_EOF     = 10'(T_EOF_US * TICKS_PER_US);
	localparam logic [9:0] T_IFS     = 10'(T_IFS_US * TICKS_PER_US);
	localparam logic [9:0] T_DEV_RST = 10'(T_DEV_RST_US * TICKS_PER_US);
	localparam logic [9:0] T_SETTLE  = 10'(T_SETTLE_US * TICKS_PER_US);
	localparam logic [9:0] W_INV     = 10'(W_INV_US * TICKS_PER_US);
	localparam logic [9:0] W_SHORT   = 10'(W_SHORT_US * TICKS_PER_US);
	localparam logic [9:0] W_LONG    = 10'(W_LONG_US * TICKS_PER_US);
	localparam logic [9:0] W_SOF     = 10'(W_SOF_US * TICKS_PER_US);
	localparam logic [9:0] CNT_MAX   = 10'h3FF;

	// ****************************************************************
	// Frame content
	// ****************************************************************
	localparam logic [7:0] CRC_POLY  = 8'h1D;
	localparam logic [7:0] CRC_INIT  = 8'hFF;
	localparam logic [7:0] CRC_GOOD  = 8'hC4;
	localparam logic [3:0] MAX_BYTES = 4'hC;
	localparam logic [3:0] MIN_BYTES = 4'h2;

	// Transmit buffer word: {ifr, last, data}
	localparam int BUF_W         = 10;
	localparam int FLD_LAST      = 8;
	localparam int FLD_IFR       = 9;

	// ****************************************************************
	// State types
	// ****************************************************************
	typedef enum logic [5:0] {
		TX_IDLE  = 6'h01,
		TX_WAIT  = 6'h02,
		TX_SOF   = 6'h04,
		TX_BIT   = 6'h08,
		TX_EOD   = 6'h10,
		TX_DRAIN = 6'h20
	} tx_state_e;

	typedef enum logic [2:0] {
		CFG_RST  = 3'h1,
		CFG_LOAD = 3'h2,
		CFG_RUN  = 3'h4
	} cfg_state_e;

	typedef struct packed {
		logic [4:0]  div;
		logic        tick;
		logic        s1;
		logic        s2;
		cfg_state_e  cst;
		logic [9:0]  ccnt;
		logic        dev_rst_n;
		logic        cfg_load;
		logic        node_ready;
		logic        lvl;
		logic [9:0]  rcnt;
		logic        infr;
		logic        after_eod;
		logic [7:0]  rsh;
		logic [2:0]  rbitn;
		logic [7:0]  rcrc;
		logic [3:0]  rnbytes;
		logic        rx_vld;
		logic [7:0]  rx_byte;
		logic        rx_ok;
		logic        rx_err;
		tx_state_e   tst;
		logic [9:0]  tcnt;
		logic [9:0]  tlen;
		logic [7:0]  tsh;
		logic [2:0]  tbitn;
		logic [7:0]  tcrc;
		logic [3:0]  tnbytes;
		logic        crcph;
		logic        last;
		logic        drive;
		logic        tx_done;
		logic        tx_lost;
	} node_s;

	typedef struct packed {
		logic [BUF_W-1:0] e0;
		logic [BUF_W-1:0] e1;
		logic             v0;
		logic             v1;
		logic             rdy;
	} buf_s;

endpackage

//--- hdl/vpw_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock domain; in_ready and out_valid come from flops.
`timescale 1ns/10ps
module vpw_buf2 #(
	parameter int W = vpw_pkg::BUF_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         nrst,
	// Filling side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Draining side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);

	typedef struct packed {
		logic [W-1:0] e0;
		logic [W-1:0] e1;
		logic         v0;
		logic         v1;
		logic         rdy;
	} slot_s;

	slot_s q;
	slot_s d;

	assign in_ready  = q.rdy;
	assign out_valid = q.v0;
	assign out_data  = q.e0;

	always_comb begin
		logic push;
		logic pop;
		push = 1'b0;
		pop  = 1'b0;
		d    = q;
		push = in_valid && q.rdy;
		pop  = out_ready && q.v0;
		if (pop) begin
			d.e0 = q.e1;
			d.v0 = q.v1;
			d.v1 = 1'b0;
		end
		if (push) begin
			if (!d.v0) begin
				d.e0 = in_data;
				d.v0 = 1'b1;
			end else begin
				d.e1 = in_data;
				d.v1 = 1'b1;
			end
		end
		// Registered ready keeps the port straight from a flop
		d.rdy = !(d.v0 && d.v1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{rdy: 1'b1, default: '0};
		end else begin
			q <= d;
		end
	end

endmodule

//--- hdl/vpw_bus_node.sv
// VPW class B bus node that drives a link controller device and the
// shared single wire. Assumes an external pull-down (passive) on the
// wire, an open-drain driver from bus_out/bus_oe and a 40 MHz clock.
`timescale 1ns/10ps
module vpw_bus_node (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Device control
	output logic            dev_rst_n,
	output logic            cfg_load,
	output logic [1:0]      cfg_divisor,
	output logic            node_ready,
	// Transmit byte stream
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_last,
	input  wire logic       tx_ifr,
	output logic            tx_done,
	output logic            tx_lost,
	// Receive byte stream
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            rx_frame_ok,
	output logic            rx_frame_err,
	// Bus wire
	input  wire logic       bus_in,
	output logic            bus_out,
	output logic            bus_oe
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] crc_bit(input logic [7:0] c,
	                                       input logic       b);
		logic fb;
		fb = c[7] ^ b;
		crc_bit = {c[6:0], 1'b0} ^ (fb ? vpw_pkg::CRC_POLY : 8'h00);
	endfunction

	// Long for passive one or active zero
	function automatic logic [9:0] bit_len(input logic b,
	                                       input logic act);
		bit_len = (b ^ act) ? vpw_pkg::T_LONG : vpw_pkg::T_SHORT;
	endfunction

	vpw_pkg::node_s         q;
	vpw_pkg::node_s         d;
	logic                   f_valid;
	logic [vpw_pkg::BUF_W-1:0] f_data;
	logic                   pop;

	// ****************************************************************
	// Transmit buffer
	// ****************************************************************
	vpw_buf2 #(
		.W (vpw_pkg::BUF_W)
	) u_buf (
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (tx_valid),
		.in_ready  (tx_ready),
		.in_data   ({tx_ifr, tx_last, tx_data}),
		.out_valid (f_valid),
		.out_ready (pop),
		.out_data  (f_data)
	);

	assign dev_rst_n    = q.dev_rst_n;
	assign cfg_load     = q.cfg_load;
	assign cfg_divisor  = vpw_pkg::OSC_DIV_FIELD;
	assign node_ready   = q.node_ready;
	assign tx_done      = q.tx_done;
	assign tx_lost      = q.tx_lost;
	assign rx_valid     = q.rx_vld;
	assign rx_data      = q.rx_byte;
	assign rx_frame_ok  = q.rx_ok;
	assign rx_frame_err = q.rx_err;
	// Open drain: drive only the active level
	assign bus_out      = q.drive;
	assign bus_oe       = q.drive;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		logic       edge_seen;
		logic       have_bit;
		logic       bitv;
		logic       drop;
		logic       idle;
		logic       eod_win;
		logic [7:0] nsh;
		logic [7:0] ncrc;
		logic [2:0] nbit;
		edge_seen = 1'b0;
		have_bit  = 1'b0;
		bitv      = 1'b0;
		drop      = 1'b0;
		idle      = 1'b0;
		eod_win   = 1'b0;
		nsh       = 8'h00;
		ncrc      = 8'h00;
		nbit      = 3'h0;
		d         = q;
		pop       = 1'b0;
		d.tick    = 1'b0;
		d.cfg_load = 1'b0;
		d.rx_vld  = 1'b0;
		d.rx_ok   = 1'b0;
		d.rx_err  = 1'b0;
		d.tx_done = 1'b0;
		d.tx_lost = 1'b0;

		d.div = q.div + 5'h01;
		if (q.div == vpw_pkg::TICK_LAST) begin
			d.div  = 5'h00;
			d.tick = 1'b1;
		end
		d.s1 = bus_in;
		d.s2 = q.s1;

		// ************************************************************
		// Device bring-up
		// ************************************************************
		case (q.cst)
			vpw_pkg::CFG_RST: begin
				d.dev_rst_n = 1'b0;
				if (q.tick) begin
					d.ccnt = q.ccnt + 10'h001;
				end
				if (q.ccnt == vpw_pkg::T_DEV_RST) begin
					d.dev_rst_n = 1'b1;
					d.cst = vpw_pkg::CFG_LOAD;
				end
			end
			vpw_pkg::CFG_LOAD: begin
				d.cfg_load   = 1'b1;
				d.node_ready = 1'b1;
				d.cst        = vpw_pkg::CFG_RUN;
			end
			vpw_pkg::CFG_RUN: begin
				d.cst = vpw_pkg::CFG_RUN;
			end
			default: begin
				d.cst = vpw_pkg::CFG_RST;
			end
		endcase

		// ************************************************************
		// Receiver
		// ************************************************************
		// synced level is the wired-OR
		edge_seen = q.s2 != q.lvl;
		if (edge_seen) begin
			d.lvl  = q.s2;
			d.rcnt = 10'h000;
			if (q.lvl) begin
				if (q.rcnt < vpw_pkg::W_INV) begin
					drop = 1'b1;
				end else if (q.rcnt < vpw_pkg::W_SHORT) begin
					have_bit = 1'b1;
					bitv     = 1'b1;
				end else if (q.rcnt < vpw_pkg::W_LONG) begin
					have_bit = 1'b1;
				end else if (q.rcnt < vpw_pkg::W_SOF) begin
					d.infr      = 1'b1;
					d.after_eod = 1'b0;
					d.rcrc      = vpw_pkg::CRC_INIT;
					d.rbitn     = 3'h0;
					d.rnbytes   = 4'h0;
				end else begin
					drop = 1'b1;
				end
			end else begin
				if (q.rcnt < vpw_pkg::W_INV) begin
					drop = 1'b1;
				end else if (q.rcnt < vpw_pkg::W_SHORT) begin
					have_bit = 1'b1;
				end else if (q.rcnt < vpw_pkg::W_LONG) begin
					have_bit = 1'b1;
					bitv     = 1'b1;
				end
			end
		end else if (q.tick && q.rcnt != vpw_pkg::CNT_MAX) begin
			d.rcnt = q.rcnt + 10'h001;
			// end of data after passive wait
			if (!q.lvl && q.rcnt == vpw_pkg::T_EOD - 10'h001
			    && q.infr && !q.after_eod) begin
				d.after_eod = 1'b1;
				if (q.rbitn != 3'h0 || q.rnbytes < vpw_pkg::MIN_BYTES)
				begin
					d.rx_err = 1'b1;
				end else if (q.rcrc == vpw_pkg::CRC_GOOD) begin
					d.rx_ok = 1'b1;
				end else begin
					d.rx_err = 1'b1;
				end
			end
			if (!q.lvl && q.rcnt == vpw_pkg::T_EOF - 10'h001) begin
				d.infr      = 1'b0;
				d.after_eod = 1'b0;
			end
		end

		if (drop && q.infr) begin
			d.rx_err    = !q.after_eod;
			d.infr      = 1'b0;
			d.after_eod = 1'b0;
		end
		if (have_bit && q.infr) begin
			if (q.after_eod) begin
				d.after_eod = 1'b0;
				d.rcrc      = vpw_pkg::CRC_INIT;
				d.rbitn     = 3'h0;
				d.rnbytes   = 4'h0;
			end else begin
				d.rsh   = {q.rsh[6:0], bitv};
				d.rcrc  = crc_bit(q.rcrc, bitv);
				d.rbitn = q.rbitn + 3'h1;
				if (q.rbitn == 3'h7) begin
					d.rx_vld   = 1'b1;
					d.rx_byte  = {q.rsh[6:0], bitv};
					d.rnbytes  = q.rnbytes + 4'h1;
					if (q.rnbytes == vpw_pkg::MAX_BYTES) begin
						d.rx_err = 1'b1;
						d.infr   = 1'b0;
					end
				end
			end
		end

		// ************************************************************
		// Transmitter
		// ************************************************************
		// idle only after full separation
		idle    = !q.lvl && !q.s2 && q.rcnt >= vpw_pkg::T_IFS;
		eod_win = !q.lvl && !q.s2 && q.infr && q.after_eod;
		case (q.tst)
			vpw_pkg::TX_IDLE: begin
				if (q.node_ready && f_valid) begin
					d.tst = vpw_pkg::TX_WAIT;
				end
			end
			vpw_pkg::TX_WAIT: begin
				if (f_data[vpw_pkg::FLD_IFR] ? eod_win : idle) begin
					pop       = 1'b1;
					d.tsh     = f_data[7:0];
					d.last    = f_data[vpw_pkg::FLD_LAST];
					d.tcrc    = vpw_pkg::CRC_INIT;
					d.tnbytes = 4'h1;
					d.crcph   = 1'b0;
					d.tcnt    = 10'h000;
					d.drive   = 1'b1;
					d.tst     = vpw_pkg::TX_SOF;
					d.tlen    = f_data[vpw_pkg::FLD_IFR] ?
					            vpw_pkg::T_SHORT : vpw_pkg::T_SOF;
				end
			end
			vpw_pkg::TX_SOF: begin
				if (q.tick) begin
					d.tcnt = q.tcnt + 10'h001;
					if (q.tcnt == q.tlen - 10'h001) begin
						d.tcnt  = 10'h000;
						d.tbitn = 3'h0;
						d.drive = 1'b0;
						d.tlen  = bit_len(q.tsh[7], 1'b0);
						d.tst   = vpw_pkg::TX_BIT;
					end
				end
			end
			vpw_pkg::TX_BIT: begin
				// Another node held the wire while we were passive
				if (!q.drive && q.s2 && q.tcnt >= vpw_pkg::T_SETTLE) begin
					d.drive   = 1'b0;
					d.tx_lost = 1'b1;
					d.tst = q.last ? vpw_pkg::TX_IDLE : vpw_pkg::TX_DRAIN;
				end else if (q.tick) begin
					d.tcnt = q.tcnt + 10'h001;
					if (q.tcnt == q.tlen - 10'h001) begin
						ncrc    = q.crcph ? q.tcrc : crc_bit(q.tcrc, q.tsh[7]);
						nsh     = {q.tsh[6:0], 1'b0};
						nbit    = q.tbitn + 3'h1;
						d.tcrc  = ncrc;
						d.tcnt  = 10'h000;
						d.tbitn = nbit;
						if (q.tbitn != 3'h7) begin
							d.tsh   = nsh;
							d.drive = nbit[0];
							d.tlen  = bit_len(nsh[7], nbit[0]);
						end else if (q.crcph) begin
							d.drive = 1'b0;
							d.tlen  = vpw_pkg::T_EOD;
							d.tst   = vpw_pkg::TX_EOD;
						end else if (q.last || !f_valid
						             || q.tnbytes == vpw_pkg::MAX_BYTES
						                - 4'h1) begin
							d.tsh   = ~ncrc;
							d.crcph = 1'b1;
							d.drive = 1'b0;
							d.tlen  = bit_len(~ncrc[7], 1'b0);
						end else begin
							pop       = 1'b1;
							d.tsh     = f_data[7:0];
							d.last    = f_data[vpw_pkg::FLD_LAST];
							d.tnbytes = q.tnbytes + 4'h1;
							d.drive   = 1'b0;
							d.tlen    = bit_len(f_data[7], 1'b0);
						end
					end
				end
			end
			vpw_pkg::TX_EOD: begin
				if (q.tick) begin
					d.tcnt = q.tcnt + 10'h001;
					if (q.tcnt == q.tlen - 10'h001) begin
						d.tx_done = 1'b1;
						d.tst = q.last ? vpw_pkg::TX_IDLE :
						        vpw_pkg::TX_DRAIN;
					end
				end
			end
			// Discards the unsent tail of an aborted frame
			vpw_pkg::TX_DRAIN: begin
				if (f_valid) begin
					pop = 1'b1;
					if (f_data[vpw_pkg::FLD_LAST]) begin
						d.tst = vpw_pkg::TX_IDLE;
					end
				end
			end
			default: begin
				d.drive = 1'b0;
				d.tst   = vpw_pkg::TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			q <= '{tst: vpw_pkg::TX_IDLE, cst: vpw_pkg::CFG_RST,
			       default: '0};
		end else begin
			q <= d;
		end
	end

endmodule

//--- verification/vpw_node_properties.sv
// Concurrent checks on the ports of the VPW bus node.
// Assumes a 40 MHz clock, so one internal tick is 20 clk.
`timescale 1ns/10ps
module vpw_node_properties (
	// Clock and reset
	input wire logic       clk,
	input wire logic       nrst,
	// Device control
	input wire logic       dev_rst_n,
	input wire logic       cfg_load,
	input wire logic [1:0] cfg_divisor,
	input wire logic       node_ready,
	// Streams
	input wire logic       tx_done,
	input wire logic       rx_valid,
	input wire logic       rx_frame_ok,
	input wire logic       rx_frame_err,
	// Wire
	input wire logic       bus_out,
	input wire logic       bus_oe
);
	// ********************
	// Level run counters
	// ********************
	// lo_q saturates so a long idle never wraps into a legal length; hi_q wraps
	logic [15:0] hi_q;
	logic [15:0] lo_q;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			hi_q <= 16'h0000;
			lo_q <= 16'h0000;
		end else begin
			hi_q <= bus_oe ? hi_q + 16'h0001 : 16'h0000;
			lo_q <= bus_oe ? 16'h0000 :
				(lo_q == 16'hffff ? lo_q : lo_q + 16'h0001);
		end
	end

	// ********************
	// Properties
	// ********************
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	a_oe_follows_out: assert property (bus_oe == bus_out)
		else $error("bus_oe differs from bus_out");
	a_quiet_before_cfg: assert property (!node_ready |-> !bus_oe)
		else $error("wire driven before configuration");
	a_cfg_after_dev: assert property (
		$rose(dev_rst_n) |=> cfg_load && node_ready)
		else $error("no configuration load after device reset");
	a_divisor_fixed: assert property (
		cfg_divisor == vpw_pkg::OSC_DIV_FIELD)
		else $error("wrong oscillator divisor field");
	a_active_len: assert property ($fell(bus_oe) |->
		hi_q inside {[2540:2580], [5100:5140], [7980:8020]})
		else $error("active period of illegal length");
	a_passive_len: assert property (
		$rose(bus_oe) && lo_q < 7000 |->
		lo_q inside {[2540:2580], [5100:5140]})
		else $error("passive bit of illegal length");
	a_eod_done: assert property (
		tx_done |-> !bus_oe && lo_q inside {[7960:8040]})
		else $error("frame done without 200 us passive");
	a_status_once: assert property (
		!(rx_frame_ok && rx_frame_err))
		else $error("frame both good and bad");
	a_byte_pulse: assert property (rx_valid |=> !rx_valid)
		else $error("byte strobe longer than one cycle");
endmodule

bind vpw_bus_node vpw_node_properties u_props (
	.clk(clk), .nrst(nrst), .dev_rst_n(dev_rst_n),
	.cfg_load(cfg_load), .cfg_divisor(cfg_divisor),
	.node_ready(node_ready), .tx_done(tx_done), .rx_valid(rx_valid),
	.rx_frame_ok(rx_frame_ok), .rx_frame_err(rx_frame_err),
	.bus_out(bus_out), .bus_oe(bus_oe)
);

//--- verification/vpw_peer.sv
// Behavioural far-side node: sends two-byte frames and decodes the wire.
// Assumes a 40 MHz clock and a pulled-down wire, 1 = active.
`timescale 1ns/10ps
module vpw_peer (
	// Clock
	input wire logic  clk,
	// Wire
	input wire logic  bus_lvl,
	output logic      drive,
	// Decoded bytes
	output logic      byte_vld,
	output logic [7:0] byte_val
);
	localparam int SH = 2560;
	localparam int LG = 5120;
	logic       prev;
	logic [7:0] sh;
	int         cnt;
	int         nb;

	initial begin
		drive = 1'b0;
		prev = 1'b0;
		sh = 8'h00;
		cnt = 0;
		nb = 0;
	end

	// ********************
	// Decoder
	// ********************
	// interval between edges
	always @(posedge clk) begin
		byte_vld <= 1'b0;
		if (bus_lvl !== prev) begin
			if (cnt > 6520)
				nb = 0;
			else begin
				sh = {sh[6:0], 1'((cnt > 3840) ^ prev)};
				nb++;
				if (nb == 8) begin
					byte_val <= sh;
					byte_vld <= 1'b1;
					nb = 0;
				end
			end
			cnt = 0;
		end else
			cnt++;
		prev = bus_lvl;
	end

	// ********************
	// Sender
	// ********************
	task automatic send(input logic [7:0] b0, input logic [7:0] b1);
		logic [15:0] s;
		logic        lv;
		s = {b0, b1};
		for (int i = 0; i < 12000; i++) begin
			@(negedge clk);
			if (bus_lvl)
				i = 0;
		end
		drive = 1'b1;
		repeat (8000) @(negedge clk);
		lv = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			drive = lv;
			repeat ((s[i] ^ lv) ? LG : SH) @(negedge clk);
			lv = !lv;
		end
		drive = 1'b0;
		repeat (8000) @(negedge clk);
	endtask
endmodule

//--- verification/tb.sv
// Self-checking bench for the VPW bus node with one peer on the wire.
// Assumes the node receives its own frames as the note states.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
	logic       clk, nrst, tx_valid, tx_last, tx_ifr, peer_drive, pk_vld;
	logic [7:0] tx_data, rx_data, pk_byte, a, b, d, bad;
	logic       dev_rst_n, cfg_load, node_ready, tx_ready, tx_done;
	logic       tx_lost, rx_valid, rx_frame_ok, rx_frame_err;
	logic       bus_out, bus_oe;
	logic [1:0] cfg_divisor;
	logic [7:0] exp_q[$], pk_q[$], f[$];
	logic       st_q[$];
	int         err_total, n_tests, seed, done_n;
	wire logic  bus_lvl = bus_oe | peer_drive;

	vpw_bus_node dut (.clk(clk), .nrst(nrst), .dev_rst_n(dev_rst_n),
		.cfg_load(cfg_load), .cfg_divisor(cfg_divisor),
		.node_ready(node_ready), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_data(tx_data), .tx_last(tx_last), .tx_ifr(tx_ifr),
		.tx_done(tx_done), .tx_lost(tx_lost), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_frame_ok(rx_frame_ok),
		.rx_frame_err(rx_frame_err), .bus_in(bus_lvl), .bus_out(bus_out),
		.bus_oe(bus_oe));
	vpw_peer peer (.clk(clk), .bus_lvl(bus_lvl), .drive(peer_drive),
		.byte_vld(pk_vld), .byte_val(pk_byte));

	// ********************
	// Helpers
	// ********************
	function automatic logic [7:0] crc8(input logic [7:0] q[$]);
		logic [7:0] c;
		c = vpw_pkg::CRC_INIT;
		foreach (q[k])
			for (int i = 7; i >= 0; i--)
				c = {c[6:0], 1'b0} ^
					((c[7] ^ q[k][i]) ? vpw_pkg::CRC_POLY : 8'h00);
		return ~c;
	endfunction

	task automatic push(input logic [7:0] v, input logic l);
		tx_valid = 1'b1;
		tx_data = v;
		tx_last = l;
		for (int i = 0; i < 100 && tx_ready !== 1'b1; i++)
			@(negedge clk);
		@(negedge clk);
	endtask

	task automatic drain(input int n);
		for (int i = 0; i < n && exp_q.size() + pk_q.size() + st_q.size()
			!= 0; i++)
			@(negedge clk);
	endtask

	task complete_run;
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ********************
	// Watchers
	// ********************
	always @(negedge clk) begin
		if (rx_valid === 1'b1)
			`CHK(rx_data, exp_q.pop_front())
		if (pk_vld === 1'b1)
			`CHK(pk_byte, pk_q.pop_front())
		if (rx_frame_ok === 1'b1 || rx_frame_err === 1'b1)
			`CHK(rx_frame_ok, st_q.pop_front())
		if (tx_done === 1'b1)
			done_n++;
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#(400000 * 25);
		err_total++;
		complete_run();
	end

	// ********************
	// Main sequence
	// ********************
	initial begin
		seed = 32'h8c25_7756;
		{err_total, n_tests, done_n} = '0;
		{nrst, tx_valid, tx_last, tx_ifr} = 4'h0;
		tx_data = 8'h00;
		a = 8'($random(seed));
		b = 8'($random(seed));
		d = 8'($random(seed));
		repeat (8) @(negedge clk);
		`CHK({dev_rst_n, node_ready, tx_ready, bus_oe}, 4'h2)
		nrst = 1'b1;
		f = '{a, b};
		exp_q = '{a, b, crc8(f)};
		pk_q = '{a, b, crc8(f)};
		st_q.push_back(1'b1);
		push(a, 1'b0);
		push(b, 1'b1);
		// Buffer holds both words while the node is still unconfigured
		`CHK(tx_ready, 1'b0)
		tx_valid = 1'b0;
		for (int i = 0; i < 1000 && node_ready !== 1'b1; i++)
			@(negedge clk);
		`CHK(cfg_divisor, vpw_pkg::OSC_DIV_FIELD)
		drain(200000);
		`CHK(done_n, 1)
		f = '{d};
		bad = crc8(f) ^ 8'h01;
		exp_q = '{d, bad};
		pk_q = '{d, bad};
		st_q.push_back(1'b0);
		peer.send(d, bad);
		drain(40000);
		`CHK(exp_q.size() + pk_q.size() + st_q.size(), 0)
		complete_run();
	end
endmodule
